// ===== logic/tirp_params.svh
// What this block does
// - The controller is only ever a bus slave and never starts traffic on the bus.
// - The controller answers to one of two slave address pairs, 0xBA/0xBB or 0x28/0x29.
// - The level on the interrupt line at reset release picks which address pair is used.
// - On a matching address byte the controller drives SDA low for the ninth clock.
// - On an address that does not match the controller stays silent until the next start.
// - Every byte is eight data bits and one acknowledge bit from the receiving party.
// - SDA is sampled while SCL is high and only changes while SCL is low.
// - The register pointer steps up by one after each data byte written.
// - In a burst read bytes keep coming while the host acknowledges, ending on a NACK.
// - The external reset pin is active low and holds the controller in reset.
// - The controller drives an interrupt line to tell the host about new touch data.
`ifndef TIRP_PARAMS_SVH
`define TIRP_PARAMS_SVH

// =====================================================================
// Slave addresses
`define TIRP_ADDR_PRI 7'h5d
`define TIRP_ADDR_ALT 7'h14

// =====================================================================
// Byte framing and pointer
`define TIRP_LAST_DATA_BIT 4'h7
`define TIRP_ACK_BIT 4'h8
`define TIRP_PTR_W 16
`define TIRP_PTR_RESET 16'h0000
`define TIRP_BYTE_RESET 8'h00

`endif

// ===== logic/tirp_pkg.sv
package tirp_pkg;

    // =================================================================
    // Transfer states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_DEV    = 3'b001,
        ST_PTR_HI = 3'b010,
        ST_PTR_LO = 3'b011,
        ST_WR     = 3'b100,
        ST_RD     = 3'b101,
        ST_IGNORE = 3'b110
    } tirp_state_t;

endpackage : tirp_pkg

// ===== logic/tirp_bit_if.sv
`timescale 1ns/1ps
interface tirp_bit_if;
    logic bit_val;
    logic bit_tgl;

    // The sampler on the bus clock produces, the core clock side consumes.
    modport link (output bit_val, output bit_tgl);
    modport core (input bit_val, input bit_tgl);
endinterface : tirp_bit_if

// ===== logic/tirp_bit_sampler.sv
`timescale 1ns/1ps
module tirp_bit_sampler (
    input wire logic scl,
    input wire logic sda,
    tirp_bit_if.link bus
);
    logic bit_val_q;
    // The bus clock side has no reset, so the toggle starts from a known level.
    logic bit_tgl_q = 1'b0;

    // =================================================================
    // Bus clock domain
    // Each rising SCL edge captures SDA and flips the toggle; the value stays
    // stable a whole SCL period, long enough for the core side to read it.
    always_ff @(posedge scl) begin
        bit_val_q <= sda;
        bit_tgl_q <= ~bit_tgl_q;
    end

    assign bus.bit_val = bit_val_q;
    assign bus.bit_tgl = bit_tgl_q;
endmodule : tirp_bit_sampler

// ===== logic/tirp_top.sv
`timescale 1ns/1ps
`include "tirp_params.svh"
module tirp_top #(
    parameter int REG_AW = 8
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic SCL,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    input wire logic PIN_RESET_N,
    input wire logic IRQ_I,
    output logic IRQ_O,
    output logic IRQ_OE,
    input wire logic TOUCH_EVENT,
    input wire logic CORE_WR_EN,
    input wire logic [REG_AW-1:0] CORE_ADDR,
    input wire logic [7:0] CORE_WDATA,
    output logic REG_WR_VALID,
    output logic [`TIRP_PTR_W-1:0] REG_WR_ADDR,
    output logic [7:0] REG_WR_DATA
);
    localparam int REG_DEPTH = 1 << REG_AW;

    tirp_bit_if bit_bus ();

    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;
    logic tgl_s1, tgl_s2, tgl_s3;
    logic rstn_s1, rstn_s2, rstn_s3;
    logic irq_s1, irq_s2;
    logic active, start_ev, stop_ev, scl_fall, evt_bit, bit_in;
    logic [7:0] rx_byte;
    logic addr_match;
    tirp_pkg::tirp_state_t st_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic ack_pend_q;
    logic [`TIRP_PTR_W-1:0] ptr_q;
    logic alt_addr_q;
    logic sda_oe_q;
    logic int_pend_q;
    logic int_oe_q;
    logic host_wr;
    logic [7:0] mem_q [REG_DEPTH];

    // Register index taken from the low bits of the host pointer.
    function automatic logic [REG_AW-1:0] reg_idx(input logic [`TIRP_PTR_W-1:0] p);
        reg_idx = p[REG_AW-1:0];
    endfunction : reg_idx

    // =================================================================
    // Bus clock side
    // The sampler runs on SCL itself and hands each bit over by a toggle.
    tirp_bit_sampler u_sampler (
        .scl(SCL),
        .sda(SDA_I),
        .bus(bit_bus.link)
    );

    // =================================================================
    // Pin synchronisers
    // Every pin and the toggle pass two flip-flops; a third stage gives edges.
    always_ff @(posedge CLK) begin
        scl_s1 <= SCL;
        scl_s2 <= scl_s1;
        scl_s3 <= scl_s2;
        sda_s1 <= SDA_I;
        sda_s2 <= sda_s1;
        sda_s3 <= sda_s2;
        tgl_s1 <= bit_bus.bit_tgl;
        tgl_s2 <= tgl_s1;
        tgl_s3 <= tgl_s2;
        rstn_s1 <= PIN_RESET_N;
        rstn_s2 <= rstn_s1;
        irq_s1 <= IRQ_I;
        irq_s2 <= irq_s1;
    end

    // Pin reset history, cleared by the core reset.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            rstn_s3 <= 1'b0;
        end else begin
            rstn_s3 <= rstn_s2;
        end
    end

    // Bus events seen from the core clock.
    assign active = rstn_s2;
    assign start_ev = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
    assign stop_ev = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
    assign scl_fall = scl_s3 && !scl_s2;
    assign evt_bit = (tgl_s2 ^ tgl_s3) && (st_q != tirp_pkg::ST_IDLE)
        && (st_q != tirp_pkg::ST_IGNORE);
    assign bit_in = bit_bus.bit_val;
    assign rx_byte = {sh_q[6:0], bit_in};
    assign addr_match = rx_byte[7:1] == (alt_addr_q ? `TIRP_ADDR_ALT : `TIRP_ADDR_PRI);
    assign host_wr = evt_bit && (st_q == tirp_pkg::ST_WR) && (bit_cnt_q == `TIRP_LAST_DATA_BIT);

    // =================================================================
    // Address strap
    // The interrupt pin level is caught on the release of the reset pin.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            alt_addr_q <= 1'b0;
        end else if (rstn_s2 && !rstn_s3) begin
            alt_addr_q <= irq_s2;
        end
    end

    // =================================================================
    // Transfer state machine
    // Bytes are counted in rising-edge events; the ninth one is the ack bit.
    always_ff @(posedge CLK) begin
        if (RESET || !active) begin
            st_q <= tirp_pkg::ST_IDLE;
            bit_cnt_q <= 4'h0;
            sh_q <= `TIRP_BYTE_RESET;
            tx_q <= `TIRP_BYTE_RESET;
            ack_pend_q <= 1'b0;
            ptr_q <= `TIRP_PTR_RESET;
        end else if (stop_ev) begin
            st_q <= tirp_pkg::ST_IDLE;
            ack_pend_q <= 1'b0;
        end else if (start_ev) begin
            st_q <= tirp_pkg::ST_DEV;
            bit_cnt_q <= 4'h0;
            ack_pend_q <= 1'b0;
        end else if (evt_bit) begin
            if (bit_cnt_q == `TIRP_ACK_BIT) begin
                bit_cnt_q <= 4'h0;
                ack_pend_q <= 1'b0;
                if (st_q == tirp_pkg::ST_RD && !ack_pend_q) begin
                    ptr_q <= ptr_q + 1'b1;
                    tx_q <= mem_q[reg_idx(ptr_q + 1'b1)];
                    if (bit_in) begin
                        st_q <= tirp_pkg::ST_IGNORE;
                    end
                end
            end else begin
                bit_cnt_q <= bit_cnt_q + 1'b1;
                sh_q <= rx_byte;
                if (st_q == tirp_pkg::ST_RD) begin
                    tx_q <= {tx_q[6:0], 1'b0};
                end
                if (bit_cnt_q == `TIRP_LAST_DATA_BIT) begin
                    case (st_q)
                        tirp_pkg::ST_DEV: begin
                            if (addr_match) begin
                                ack_pend_q <= 1'b1;
                                if (rx_byte[0]) begin
                                    st_q <= tirp_pkg::ST_RD;
                                    tx_q <= mem_q[reg_idx(ptr_q)];
                                end else begin
                                    st_q <= tirp_pkg::ST_PTR_HI;
                                end
                            end else begin
                                st_q <= tirp_pkg::ST_IGNORE;
                            end
                        end
                        tirp_pkg::ST_PTR_HI: begin
                            ptr_q[15:8] <= rx_byte;
                            ack_pend_q <= 1'b1;
                            st_q <= tirp_pkg::ST_PTR_LO;
                        end
                        tirp_pkg::ST_PTR_LO: begin
                            ptr_q[7:0] <= rx_byte;
                            ack_pend_q <= 1'b1;
                            st_q <= tirp_pkg::ST_WR;
                        end
                        tirp_pkg::ST_WR: begin
                            ptr_q <= ptr_q + 1'b1;
                            ack_pend_q <= 1'b1;
                        end
                        default: begin
                            ack_pend_q <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // =================================================================
    // SDA drive
    // The pin changes after SCL falls and is also released on a start or stop; it is only ever pulled low.
    always_ff @(posedge CLK) begin
        if (RESET || !active || stop_ev || start_ev) begin
            sda_oe_q <= 1'b0;
        end else if (scl_fall) begin
            if (st_q == tirp_pkg::ST_RD && bit_cnt_q < `TIRP_ACK_BIT) begin
                sda_oe_q <= ~tx_q[7];
            end else if (bit_cnt_q == `TIRP_ACK_BIT) begin
                sda_oe_q <= ack_pend_q;
            end else begin
                sda_oe_q <= 1'b0;
            end
        end
    end

    // The drive level of an open-drain line is always low.
    always_ff @(posedge CLK) begin
        SDA_O <= 1'b0;
        SDA_OE <= sda_oe_q;
    end

    // =================================================================
    // Interrupt line
    // A touch event raises the line; a host read clears it, the event wins.
    always_ff @(posedge CLK) begin
        if (RESET || !active) begin
            int_pend_q <= 1'b0;
        end else if (TOUCH_EVENT) begin
            int_pend_q <= 1'b1;
        end else if (evt_bit && st_q == tirp_pkg::ST_DEV && bit_cnt_q == `TIRP_LAST_DATA_BIT
                     && addr_match && rx_byte[0]) begin
            int_pend_q <= 1'b0;
        end
    end

    // The line is released while the strap may be applied.
    always_ff @(posedge CLK) begin
        if (RESET || !active) begin
            int_oe_q <= 1'b0;
        end else begin
            int_oe_q <= rstn_s3;
        end
    end

    assign IRQ_O = int_pend_q;
    assign IRQ_OE = int_oe_q;

    // =================================================================
    // Register bytes
    // Host writes take the slot; a core write in the same cycle is dropped.
    always_ff @(posedge CLK) begin
        if (host_wr) begin
            mem_q[reg_idx(ptr_q)] <= rx_byte;
        end else if (CORE_WR_EN) begin
            mem_q[CORE_ADDR] <= CORE_WDATA;
        end
    end

    // Write notice towards the touch core.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            REG_WR_VALID <= 1'b0;
            REG_WR_ADDR <= `TIRP_PTR_RESET;
            REG_WR_DATA <= `TIRP_BYTE_RESET;
        end else begin
            REG_WR_VALID <= host_wr && active;
            if (host_wr) begin
                REG_WR_ADDR <= ptr_q;
                REG_WR_DATA <= rx_byte;
            end
        end
    end

    // =================================================================
    // Checks
    chk_idle_quiet: assert property (@(posedge CLK) disable iff (RESET)
        (st_q == tirp_pkg::ST_IDLE) && $past(st_q == tirp_pkg::ST_IDLE) |-> !sda_oe_q)
        else $error("SDA driven while the bus is idle");
    chk_addr_ack: assert property (@(posedge CLK) disable iff (RESET)
        active && !start_ev && !stop_ev && evt_bit && st_q == tirp_pkg::ST_DEV
        && bit_cnt_q == 4'h7 && addr_match |=> ack_pend_q && st_q != tirp_pkg::ST_IGNORE)
        else $error("Matching address not acknowledged");
    chk_addr_miss: assert property (@(posedge CLK) disable iff (RESET)
        active && !start_ev && !stop_ev && evt_bit && st_q == tirp_pkg::ST_DEV
        && bit_cnt_q == 4'h7 && !addr_match |=> st_q == tirp_pkg::ST_IGNORE && !ack_pend_q)
        else $error("Foreign address not ignored");
    chk_ack_drive: assert property (@(posedge CLK) disable iff (RESET)
        active && !start_ev && !stop_ev && scl_fall && bit_cnt_q == 4'h8 && ack_pend_q
        |=> sda_oe_q ##1 SDA_OE)
        else $error("Acknowledge not driven in the ninth clock");
    chk_sda_change: assert property (@(posedge CLK) disable iff (RESET)
        $rose(sda_oe_q) |-> $past(scl_fall) && $past(!scl_s2))
        else $error("SDA pulled low outside SCL low");
    chk_wr_step: assert property (@(posedge CLK) disable iff (RESET)
        active && !start_ev && !stop_ev && host_wr |=> ptr_q == $past(ptr_q) + 16'h0001)
        else $error("Pointer did not step after a write");
    chk_rd_step: assert property (@(posedge CLK) disable iff (RESET)
        active && !start_ev && !stop_ev && evt_bit && st_q == tirp_pkg::ST_RD
        && bit_cnt_q == 4'h8 && !ack_pend_q |=> ptr_q == $past(ptr_q) + 16'h0001)
        else $error("Pointer did not step after a read byte");
    chk_rd_nack: assert property (@(posedge CLK) disable iff (RESET)
        active && !start_ev && !stop_ev && evt_bit && st_q == tirp_pkg::ST_RD
        && bit_cnt_q == 4'h8 && !ack_pend_q && bit_in |=> st_q == tirp_pkg::ST_IGNORE)
        else $error("Read went on after a NACK");
    chk_pin_reset: assert property (@(posedge CLK) disable iff (RESET)
        !rstn_s2 |=> st_q == tirp_pkg::ST_IDLE && !int_oe_q ##1 !IRQ_OE && !SDA_OE)
        else $error("Reset pin did not hold the port");
    chk_strap: assert property (@(posedge CLK) disable iff (RESET)
        rstn_s2 && !rstn_s3 |=> alt_addr_q == $past(irq_s2) ##1 int_oe_q)
        else $error("Address strap not taken at release");
    chk_int_set: assert property (@(posedge CLK) disable iff (RESET)
        active && TOUCH_EVENT ##1 active |-> IRQ_O)
        else $error("Touch event did not raise the line");
    cov_write: cover property (@(posedge CLK) disable iff (RESET) host_wr ##[1:1000] host_wr);
    cov_read: cover property (@(posedge CLK) disable iff (RESET)
        st_q == tirp_pkg::ST_RD && evt_bit && bit_cnt_q == 4'h8 && bit_in);
    cov_miss: cover property (@(posedge CLK) disable iff (RESET)
        st_q == tirp_pkg::ST_DEV ##1 st_q == tirp_pkg::ST_IGNORE);
endmodule : tirp_top

// ===== verif/tirp_host_model.sv
`timescale 1ns/1ps
module tirp_host_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda,
    output logic got,
    output logic [7:0] got_data
);
    // Half of one 80 ns bit period; the bus clock stands high between frames.
    localparam time HALF = 40ns;

    // The bus idles with the clock high and data released to the pull-up.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        got = 1'b0;
        got_data = 8'h00;
    end

    // Start or repeated start: data falls while the clock is high.
    task automatic start_c();
        sda_low = 1'b0;
        #HALF;
        scl = 1'b1;
        #HALF;
        sda_low = 1'b1;
        #HALF;
        scl = 1'b0;
    endtask : start_c

    // One bit: data moves only while the clock is low and is sampled mid-high.
    task automatic clk_bit(input logic b, output logic s);
        sda_low = ~b;
        #HALF;
        scl = 1'b1;
        #(HALF / 2);
        s = sda;
        #(HALF / 2);
        scl = 1'b0;
    endtask : clk_bit

    // Eight bits MSB first, then the receiver's acknowledge in the ninth clock.
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], s);
        end
        clk_bit(1'b1, s);
        ack = ~s;
    endtask : wr_byte

    // Clock in a byte and answer ACK to continue or NACK on the last one.
    task automatic rd_byte(input logic ack);
        logic s;
        logic [7:0] d;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            d[i] = s;
        end
        clk_bit(~ack, s);
        got_data = d;
        got = 1'b1;
        #1;
        got = 1'b0;
    endtask : rd_byte

    // Stop: data rises while the clock is high, then the bus is left idle.
    task automatic stop_c();
        sda_low = 1'b1;
        #HALF;
        scl = 1'b1;
        #HALF;
        sda_low = 1'b0;
        #HALF;
    endtask : stop_c
endmodule : tirp_host_model

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic PIN_RESET_N = 1'b1;
    logic TOUCH_EVENT = 1'b0;
    logic CORE_WR_EN = 1'b0;
    logic [7:0] CORE_ADDR = 8'h00;
    logic [7:0] CORE_WDATA = 8'h00;
    logic irq_strap = 1'b0;
    logic busy = 1'b0;
    wire scl, sda_low, got, SDA_O, SDA_OE, IRQ_O, IRQ_OE, REG_WR_VALID;
    wire [7:0] got_data, REG_WR_DATA;
    wire [15:0] REG_WR_ADDR;
    wire sda_w = (SDA_OE || sda_low) ? 1'b0 : 1'b1;
    wire irq_w = IRQ_OE ? IRQ_O : irq_strap;
    int n_errors = 0;
    int check_count = 0;
    int seed = 32'h4703277c;
    logic [23:0] wq[$];
    logic [7:0] rq[$];
    logic [7:0] dat[3];
    logic [7:0] d;

    // =================================================================
    // Clock, device and host
    always #2.5 CLK = ~CLK;

    tirp_top #(.REG_AW(8)) DUT (.CLK(CLK), .RESET(RESET), .SCL(scl), .SDA_I(sda_w),
        .SDA_O(SDA_O), .SDA_OE(SDA_OE), .PIN_RESET_N(PIN_RESET_N), .IRQ_I(irq_w),
        .IRQ_O(IRQ_O), .IRQ_OE(IRQ_OE), .TOUCH_EVENT(TOUCH_EVENT), .CORE_WR_EN(CORE_WR_EN),
        .CORE_ADDR(CORE_ADDR), .CORE_WDATA(CORE_WDATA), .REG_WR_VALID(REG_WR_VALID),
        .REG_WR_ADDR(REG_WR_ADDR), .REG_WR_DATA(REG_WR_DATA));

    tirp_host_model host (.scl(scl), .sda_low(sda_low), .sda(sda_w), .got(got),
        .got_data(got_data));

    // =================================================================
    // Checking
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        check_count++;
        if (g !== e) begin
            $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
            n_errors++;
        end
    endtask : chk

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    // Each written byte is matched against the oldest expected write, mid-cycle.
    always @(negedge CLK) begin
        if (REG_WR_VALID === 1'b1) begin
            if (wq.size() == 0) chk(24'h1, 24'h0);
            else chk({REG_WR_ADDR, REG_WR_DATA}, wq.pop_front());
        end
    end

    // Each byte the host clocks in is matched against the oldest expected read.
    always @(posedge got) begin
        if (rq.size() == 0) chk(24'h1, 24'h0);
        else chk({16'h0, got_data}, {16'h0, rq.pop_front()});
    end

    // The device drive may move only while the clock is low, and never off-frame.
    always @(SDA_OE) begin
        if (RESET === 1'b0 && scl === 1'b1) chk(24'h1, 24'h0);
        if (RESET === 1'b0 && !busy && SDA_OE !== 1'b0) chk(24'h1, 24'h0);
        if (RESET === 1'b0) chk({23'h0, SDA_O}, 24'h0);
    end

    // A hung run is cut short and counted.
    initial begin
        #200us;
        n_errors++;
        wrap_up();
    end

    // =================================================================
    // Transfer helpers
    task automatic wb(input logic [7:0] b, input logic ea);
        logic a;
        host.wr_byte(b, a);
        chk({23'h0, a}, {23'h0, ea});
    endtask : wb

    task automatic begin_xfer();
        @(posedge CLK);
        #1.7;
        busy = 1'b1;
        host.start_c();
    endtask : begin_xfer

    task automatic end_xfer();
        host.stop_c();
        busy = 1'b0;
    endtask : end_xfer

    task automatic set_ptr(input logic [7:0] dev, input logic [15:0] p);
        begin_xfer();
        wb(dev, 1'b1);
        wb(p[15:8], 1'b1);
        wb(p[7:0], 1'b1);
    endtask : set_ptr

    task automatic pin_reset(input logic strap);
        @(posedge CLK);
        irq_strap <= strap;
        PIN_RESET_N <= 1'b0;
        repeat (6) @(posedge CLK);
        chk({23'h0, IRQ_OE}, 24'h0);
        PIN_RESET_N <= 1'b1;
        repeat (10) @(posedge CLK);
        irq_strap <= 1'b0;
        chk({23'h0, IRQ_OE}, 24'h1);
        repeat (10) @(posedge CLK);
    endtask : pin_reset

    // =================================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge CLK);
        RESET <= 1'b0;
        pin_reset(1'b0);
        // Burst write that carries the pointer across a byte boundary.
        set_ptr(8'hba, 16'h00fe);
        for (int i = 0; i < 3; i++) begin
            dat[i] = $random(seed);
            wq.push_back({16'h00fe + 16'(i), dat[i]});
            wb(dat[i], 1'b1);
        end
        end_xfer();
        // Burst read of the same bytes, ending on a NACK.
        set_ptr(8'hba, 16'h00fe);
        host.start_c();
        wb(8'hbb, 1'b1);
        for (int i = 0; i < 3; i++) begin
            rq.push_back(dat[i]);
            host.rd_byte(i < 2);
        end
        end_xfer();
        // The other pair is refused and its bytes ignored.
        begin_xfer();
        wb(8'h28, 1'b0);
        wb(8'h55, 1'b0);
        end_xfer();
        // Touch event raises the interrupt; core writes a byte.
        @(posedge CLK);
        TOUCH_EVENT <= 1'b1;
        CORE_WR_EN <= 1'b1;
        CORE_ADDR <= 8'h10;
        d = $random(seed);
        CORE_WDATA <= d;
        @(posedge CLK);
        TOUCH_EVENT <= 1'b0;
        CORE_WR_EN <= 1'b0;
        repeat (2) @(posedge CLK);
        chk({23'h0, IRQ_O}, 24'h1);
        // Reading clears the interrupt and returns the core byte.
        set_ptr(8'hba, 16'h0010);
        host.start_c();
        wb(8'hbb, 1'b1);
        chk({23'h0, IRQ_O}, 24'h0);
        rq.push_back(d);
        host.rd_byte(1'b0);
        end_xfer();
        // Strap high at release selects the other address pair.
        pin_reset(1'b1);
        begin_xfer();
        wb(8'hba, 1'b0);
        end_xfer();
        set_ptr(8'h28, 16'h0020);
        d = $random(seed);
        wq.push_back({16'h0020, d});
        wb(d, 1'b1);
        end_xfer();
        repeat (20) @(posedge CLK);
        chk(24'(wq.size() + rq.size()), 24'h0);
        wrap_up();
    end
endmodule : tb
